// [rtl/bfch_pkg.sv]
/*
  Constants and types of the boot flash command handler.
  Assumes a framing layer that hands over whole packets, little-endian.
*/
package bfch_pkg;

  // Command codes.
  localparam logic [7:0] TAG_FULL_ERASE   = 8'h01;
  localparam logic [7:0] TAG_REGION_ERASE = 8'h02;
  localparam logic [7:0] TAG_MEM_WRITE    = 8'h04;
  localparam logic [7:0] TAG_UNSEC_ERASE  = 8'h0d;

  // Parameter counts.
  localparam logic [7:0] PARAMS_NONE = 8'h00;
  localparam logic [7:0] PARAMS_TWO  = 8'h02;

  // Status codes.
  localparam logic [31:0] STATUS_OK            = 32'h0;
  localparam logic [31:0] STATUS_RANGE_INVALID = 32'h27d8;
  localparam logic [31:0] STATUS_MISALIGNED    = 32'h65;
  localparam logic [31:0] STATUS_OUT_OF_SPACE  = 32'h66;
  localparam logic [31:0] STATUS_ACCESS_FAULT  = 32'h67;
  localparam logic [31:0] STATUS_PROT_FAULT    = 32'h68;
  localparam logic [31:0] STATUS_OP_FAILED     = 32'h69;
  localparam logic [31:0] STATUS_BAD_CMD       = 32'h4;

  // Security byte location and values.
  localparam logic [31:0] SEC_BYTE_ADDR  = 32'h40c;
  localparam logic [7:0]  SEC_BYTE_UNSEC = 8'hfe;
  localparam logic [7:0]  ERASED_BYTE    = 8'hff;
  localparam logic [31:0] ERASED_WORD    = 32'hffff_ffff;
  localparam int          MEEN_LSB       = 4;
  localparam logic [1:0]  MEEN_OFF       = 2'h2;

  // Register byte offsets.
  localparam logic [11:0] REG_CTRL    = 12'h000;
  localparam logic [11:0] REG_PROT    = 12'h004;
  localparam logic [11:0] REG_SECBYTE = 12'h008;
  localparam logic [11:0] REG_SECURE  = 12'h00c;
  localparam logic [11:0] REG_LAST    = 12'h010;
  localparam int          CTRL_VERIFY_BIT = 0;
  localparam int          SECURE_BIT      = 0;

  // Reset values.
  localparam logic        VERIFY_RST  = 1'b0;
  localparam logic [7:0]  SECBYTE_RST = 8'hff;
  localparam logic        SECURE_RST  = 1'b0;

  typedef enum logic [2:0] {
    OP_ERASE_ALL    = 3'h0,
    OP_ERASE_SECTOR = 3'h1,
    OP_PROGRAM      = 3'h2,
    OP_VERIFY       = 3'h3,
    OP_RAM_BYTE     = 3'h4
  } bfch_op_t;

  typedef enum logic [3:0] {
    S_IDLE      = 4'h0,
    S_CHECK     = 4'h1,
    S_ERASE_ALL = 4'h2,
    S_SEC_PROG  = 4'h3,
    S_ERASE_SEC = 4'h4,
    S_WR_DATA   = 4'h5,
    S_WR_PROG   = 4'h6,
    S_WR_VERIFY = 4'h7,
    S_REPLY     = 4'h8
  } bfch_state_t;

  typedef struct packed {
    logic [7:0]  cmd_code_field;
    logic [7:0]  flags;
    logic [7:0]  param_total_field;
    logic [31:0] first_location_param;
    logic [31:0] transfer_length_param;
  } bfch_cmd_t;

  typedef struct packed {
    logic [31:0] status;
    logic [31:0] cmd_code_field;
  } bfch_reply_t;

  typedef struct packed {
    bfch_op_t    kind;
    logic [31:0] addr;
    logic [31:0] data;
  } bfch_mem_op_t;

endpackage : bfch_pkg

// [rtl/bfch_top.sv]
/*
  Boot flash command handler: three erase commands and a memory write,
  each ending in a status reply; registers on an APB slave.
  Assumes a memory controller that ends each operation with a done pulse
  and a framing layer that hands over decoded packets and data bytes.
*/
// Notes on behaviour
// RQ1: Code 01 erases whole flash, no parameters.
// RQ2: Any protected region refuses full erase.
// RQ3: Full erase clears security, erases security byte.
// RQ4: Region erase: start and count parameters.
// RQ5: Unaligned start or count gives 101.
// RQ6: Region beyond flash gives 102.
// RQ7: Protected part of region gives 10200.
// RQ8: Region erase answers only listed codes.
// RQ9: Code 0D erases everything, even protected.
// RQ10: Unsecure at once, program FE at 40C.
// RQ11: Mass erase disabled option fails command.
// RQ12: Erase commands have no data phase.
// RQ13: Code 04 writes memory, start and count.
// RQ14: Accept data bytes until count reached.
// RQ15: Writes into protected sectors fail.
// RQ16: Host erases flash before writing it.
// RQ17: Unaligned flash write start is invalid.
// RQ18: Flash count rounds up, pad with FF.
// RQ19: Verify after each program when enabled.
// RQ20: RAM writes any alignment, no padding.
// RQ21: Every command ends with status reply.
// RQ22: Reply holds status then command code.
// RQ23: Little-endian parameters inside framed packets.
// RQ24: Check alignment, then range, then protection.
`timescale 1ns/1ps
`default_nettype none
module bfch_top #(
  parameter int FLASH_BYTES  = 32768,
  parameter int SECTOR_BYTES = 1024,
  parameter int SECTORS      = 32
) (
  // Clock and reset.
  input wire logic                ref_clk_in,
  input wire logic                rst_b_in,
  // Command packets.
  input wire logic                cmd_valid_in,
  input wire bfch_pkg::bfch_cmd_t cmd_in,
  output logic                    cmd_ready_out,
  // Data phase bytes.
  input wire logic                data_valid_in,
  input wire logic [7:0]          data_byte_in,
  output logic                    data_ready_out,
  // Status replies.
  output logic                    reply_valid_out,
  output bfch_pkg::bfch_reply_t   reply_out,
  input wire logic                reply_ready_in,
  // Memory operations.
  output logic                    mem_req_out,
  output bfch_pkg::bfch_mem_op_t  mem_op_out,
  input wire logic                mem_done_in,
  input wire logic                mem_fail_in,
  // Security state.
  output logic                    flash_secured_out,
  // APB slave.
  input wire logic                psel_in,
  input wire logic                penable_in,
  input wire logic                pwrite_in,
  input wire logic [11:0]         paddr_in,
  input wire logic [31:0]         pwdata_in,
  output logic [31:0]             prdata_out,
  output logic                    pready_out,
  output logic                    pslverr_out
);

  localparam logic [32:0] FLASH_END   = 33'(FLASH_BYTES);
  localparam logic [31:0] SECTOR_STEP = 32'(SECTOR_BYTES);
  localparam logic [31:0] SECTOR_MASK = ~(32'(SECTOR_BYTES) - 32'h1);

  // Sectors touched by the byte range [a, e).
  function automatic logic [SECTORS-1:0] hit_mask(input logic [31:0] a, input logic [32:0] e);
    logic [SECTORS-1:0] m;
    logic [32:0]        lo;
    m = '0;
    for (int i = 0; i < SECTORS; i++) begin
      lo = 33'(i * SECTOR_BYTES);
      m[i] = ({1'b0, a} < lo + 33'(SECTOR_BYTES)) && (e > lo);
    end
    return m;
  endfunction : hit_mask

  // APB register group.
  logic                   verify_en;
  logic [SECTORS-1:0]     prot;
  logic [31:0]            prdata;
  logic                   next_verify_en;
  logic [SECTORS-1:0]     next_prot;
  logic [31:0]            next_prdata;
  logic                   apb_wr;
  logic                   mapped;
  logic [31:0]            rd_mux;

  // Command engine group.
  bfch_pkg::bfch_state_t  st;
  bfch_pkg::bfch_cmd_t    cmd;
  bfch_pkg::bfch_mem_op_t op;
  logic [31:0]            status;
  logic [31:0]            addr;
  logic [31:0]            remain;
  logic [32:0]            stop;
  logic [31:0]            word;
  logic [1:0]             lane;
  logic                   to_flash;
  logic [7:0]             sec_byte;
  logic                   secured;
  logic [31:0]            last_status;
  bfch_pkg::bfch_state_t  next_st;
  bfch_pkg::bfch_cmd_t    next_cmd;
  bfch_pkg::bfch_mem_op_t next_op;
  logic [31:0]            next_status;
  logic [31:0]            next_addr;
  logic [31:0]            next_remain;
  logic [32:0]            next_stop;
  logic [31:0]            next_word;
  logic [1:0]             next_lane;
  logic                   next_to_flash;
  logic [7:0]             next_sec_byte;
  logic                   next_secured;
  logic [31:0]            next_last_status;
  logic                   step;
  logic [32:0]            span_end;
  logic [32:0]            pad_end;

  assign apb_wr      = psel_in && penable_in && pwrite_in;
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;
  assign prdata_out  = prdata;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0;
    unique case (paddr_in)
      bfch_pkg::REG_CTRL:    rd_mux[bfch_pkg::CTRL_VERIFY_BIT] = verify_en;
      bfch_pkg::REG_PROT:    rd_mux = 32'(prot);
      bfch_pkg::REG_SECBYTE: rd_mux = {24'h0, sec_byte};
      bfch_pkg::REG_SECURE:  rd_mux[bfch_pkg::SECURE_BIT] = secured;
      bfch_pkg::REG_LAST:    rd_mux = last_status;
      default:               mapped = 1'b0;
    endcase
    next_verify_en = verify_en;
    next_prot      = prot;
    next_prdata    = prdata;
    if (psel_in && !penable_in && !pwrite_in) begin
      next_prdata = rd_mux;
    end
    if (apb_wr && paddr_in == bfch_pkg::REG_CTRL) begin
      next_verify_en = pwdata_in[bfch_pkg::CTRL_VERIFY_BIT];
    end
    if (apb_wr && paddr_in == bfch_pkg::REG_PROT) begin
      next_prot = pwdata_in[SECTORS-1:0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      verify_en <= bfch_pkg::VERIFY_RST;
      prot      <= '0;
      prdata    <= 32'h0;
    end else begin
      verify_en <= next_verify_en;
      prot      <= next_prot;
      prdata    <= next_prdata;
    end
  end

  assign cmd_ready_out     = (st == bfch_pkg::S_IDLE);
  assign data_ready_out    = (st == bfch_pkg::S_WR_DATA); // RQ14
  assign reply_valid_out   = (st == bfch_pkg::S_REPLY); // RQ21
  assign reply_out         = '{status: status, cmd_code_field: {24'h0, cmd.cmd_code_field}}; // RQ22
  assign mem_op_out        = op;
  assign flash_secured_out = secured;
  assign mem_req_out       = st inside {bfch_pkg::S_ERASE_ALL, bfch_pkg::S_SEC_PROG,
                                        bfch_pkg::S_ERASE_SEC, bfch_pkg::S_WR_PROG,
                                        bfch_pkg::S_WR_VERIFY};

  // Parameters arrive assembled by the framing layer.
  assign span_end = {1'b0, cmd.first_location_param} + {1'b0, cmd.transfer_length_param}; // RQ23
  assign pad_end  = {1'b0, cmd.first_location_param} +
                    (({1'b0, cmd.transfer_length_param} + 33'h3) & ~33'h3); // RQ18

  always_comb begin
    next_st          = st;
    next_cmd         = cmd;
    next_op          = op;
    next_status      = status;
    next_addr        = addr;
    next_remain      = remain;
    next_stop        = stop;
    next_word        = word;
    next_lane        = lane;
    next_to_flash    = to_flash;
    next_sec_byte    = sec_byte;
    next_secured     = secured;
    next_last_status = last_status;
    step             = 1'b0;
    // Software writes first so that a hardware update in the same cycle wins.
    if (apb_wr && paddr_in == bfch_pkg::REG_SECBYTE) begin
      next_sec_byte = pwdata_in[7:0];
    end
    if (apb_wr && paddr_in == bfch_pkg::REG_SECURE) begin
      next_secured = pwdata_in[bfch_pkg::SECURE_BIT];
    end
    unique case (st)
      bfch_pkg::S_IDLE: begin
        if (cmd_valid_in) begin
          next_cmd = cmd_in;
          next_st  = bfch_pkg::S_CHECK;
        end
      end
      bfch_pkg::S_CHECK: begin
        next_status = bfch_pkg::STATUS_OK;
        next_addr   = cmd.first_location_param;
        next_remain = cmd.transfer_length_param;
        next_stop   = span_end;
        next_word   = bfch_pkg::ERASED_WORD;
        next_lane   = 2'h0;
        next_st     = bfch_pkg::S_REPLY; // RQ12
        unique case (cmd.cmd_code_field)
          bfch_pkg::TAG_FULL_ERASE: begin
            if (cmd.param_total_field != bfch_pkg::PARAMS_NONE) begin
              next_status = bfch_pkg::STATUS_BAD_CMD;
            end else if (|prot) begin
              next_status = bfch_pkg::STATUS_PROT_FAULT; // RQ2
            end else begin
              next_op = '{kind: bfch_pkg::OP_ERASE_ALL, addr: 32'h0, data: 32'h0}; // RQ1
              next_st = bfch_pkg::S_ERASE_ALL;
            end
          end
          bfch_pkg::TAG_UNSEC_ERASE: begin
            if (cmd.param_total_field != bfch_pkg::PARAMS_NONE) begin
              next_status = bfch_pkg::STATUS_BAD_CMD;
            end else if (sec_byte[bfch_pkg::MEEN_LSB +: 2] == bfch_pkg::MEEN_OFF) begin
              next_status = bfch_pkg::STATUS_OP_FAILED; // RQ11
            end else begin
              next_secured = 1'b0; // RQ10
              next_op = '{kind: bfch_pkg::OP_ERASE_ALL, addr: 32'h0, data: 32'h0}; // RQ9
              next_st = bfch_pkg::S_ERASE_ALL;
            end
          end
          bfch_pkg::TAG_REGION_ERASE: begin
            if (cmd.param_total_field != bfch_pkg::PARAMS_TWO) begin // RQ4
              next_status = bfch_pkg::STATUS_BAD_CMD;
            end else if (|{cmd.first_location_param[1:0], cmd.transfer_length_param[1:0]}) begin
              next_status = bfch_pkg::STATUS_MISALIGNED; // RQ5 RQ24
            end else if (span_end > FLASH_END) begin
              next_status = bfch_pkg::STATUS_OUT_OF_SPACE; // RQ6
            end else if (|(prot & hit_mask(cmd.first_location_param, span_end))) begin
              next_status = bfch_pkg::STATUS_RANGE_INVALID; // RQ7
            end else if (|cmd.transfer_length_param) begin
              next_op = '{kind: bfch_pkg::OP_ERASE_SECTOR,
                          addr: cmd.first_location_param & SECTOR_MASK, data: 32'h0};
              next_st = bfch_pkg::S_ERASE_SEC;
            end
          end
          bfch_pkg::TAG_MEM_WRITE: begin
            next_to_flash = ({1'b0, cmd.first_location_param} < FLASH_END);
            if (cmd.param_total_field != bfch_pkg::PARAMS_TWO) begin // RQ13
              next_status = bfch_pkg::STATUS_BAD_CMD;
            end else begin
              if (next_to_flash) begin
                if (cmd.first_location_param[1:0] != 2'h0) begin
                  next_status = bfch_pkg::STATUS_MISALIGNED; // RQ17
                end else if (pad_end > FLASH_END) begin
                  next_status = bfch_pkg::STATUS_OUT_OF_SPACE;
                end else if (|(prot & hit_mask(cmd.first_location_param, pad_end))) begin
                  next_status = bfch_pkg::STATUS_PROT_FAULT; // RQ15
                end
              end
              if (|cmd.transfer_length_param) begin
                next_st = bfch_pkg::S_WR_DATA; // RQ14
              end
            end
          end
          default: begin
            next_status = bfch_pkg::STATUS_BAD_CMD;
          end
        endcase
      end
      bfch_pkg::S_ERASE_ALL: begin
        if (mem_done_in) begin
          next_st = bfch_pkg::S_REPLY;
          if (mem_fail_in) begin
            next_status = bfch_pkg::STATUS_OP_FAILED;
          end else if (cmd.cmd_code_field == bfch_pkg::TAG_UNSEC_ERASE) begin
            next_op = '{kind: bfch_pkg::OP_PROGRAM, addr: bfch_pkg::SEC_BYTE_ADDR,
                        data: {24'hff_ffff, bfch_pkg::SEC_BYTE_UNSEC}}; // RQ10
            next_st = bfch_pkg::S_SEC_PROG;
          end else begin
            next_sec_byte = bfch_pkg::ERASED_BYTE; // RQ3
            next_secured  = 1'b0; // RQ3
          end
        end
      end
      bfch_pkg::S_SEC_PROG: begin
        if (mem_done_in) begin
          next_st = bfch_pkg::S_REPLY;
          if (mem_fail_in) begin
            next_status = bfch_pkg::STATUS_OP_FAILED;
          end else begin
            next_sec_byte = bfch_pkg::SEC_BYTE_UNSEC; // RQ10
          end
        end
      end
      bfch_pkg::S_ERASE_SEC: begin
        if (mem_done_in) begin
          next_op.addr = op.addr + SECTOR_STEP;
          if (mem_fail_in) begin
            next_status = bfch_pkg::STATUS_OP_FAILED; // RQ8
            next_st     = bfch_pkg::S_REPLY;
          end else if ({1'b0, op.addr} + 33'(SECTOR_BYTES) >= stop) begin
            next_st = bfch_pkg::S_REPLY;
          end
        end
      end
      bfch_pkg::S_WR_DATA: begin
        if (data_valid_in) begin
          next_remain = remain - 32'h1;
          if (!to_flash) begin
            // Each byte goes out at its own address with no padding.
            next_op = '{kind: bfch_pkg::OP_RAM_BYTE, addr: addr, data: {24'h0, data_byte_in}}; // RQ20
            if (status == bfch_pkg::STATUS_OK) begin
              next_st = bfch_pkg::S_WR_PROG;
            end else begin
              step = 1'b1;
            end
          end else begin
            next_word[8*lane +: 8] = data_byte_in;
            next_lane = lane + 2'h1;
            // Lanes not yet filled keep the erased pattern on the last word.
            if (lane == 2'h3 || remain == 32'h1) begin // RQ18
              next_op = '{kind: bfch_pkg::OP_PROGRAM, addr: addr, data: next_word};
              if (status == bfch_pkg::STATUS_OK) begin
                next_st = bfch_pkg::S_WR_PROG;
              end else begin
                step = 1'b1;
              end
            end
          end
        end
      end
      bfch_pkg::S_WR_PROG: begin
        if (mem_done_in) begin
          if (mem_fail_in) begin
            next_status = bfch_pkg::STATUS_OP_FAILED;
            step = 1'b1;
          end else if (to_flash && verify_en) begin
            next_op.kind = bfch_pkg::OP_VERIFY; // RQ19
            next_st = bfch_pkg::S_WR_VERIFY;
          end else begin
            step = 1'b1;
          end
        end
      end
      bfch_pkg::S_WR_VERIFY: begin
        if (mem_done_in) begin
          if (mem_fail_in) begin
            next_status = bfch_pkg::STATUS_OP_FAILED;
          end
          step = 1'b1;
        end
      end
      bfch_pkg::S_REPLY: begin
        if (reply_ready_in) begin
          next_last_status = status;
          next_st = bfch_pkg::S_IDLE;
        end
      end
      default: begin
        next_st = bfch_pkg::S_IDLE;
      end
    endcase
    // Next byte or word; after a failure the rest of the data is drained unwritten.
    if (step) begin
      next_addr = addr + (to_flash ? 32'h4 : 32'h1);
      next_word = bfch_pkg::ERASED_WORD;
      next_lane = 2'h0;
      next_st   = (next_remain == 32'h0) ? bfch_pkg::S_REPLY : bfch_pkg::S_WR_DATA; // RQ14
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      st          <= bfch_pkg::S_IDLE;
      cmd         <= '0;
      op          <= '0;
      status      <= bfch_pkg::STATUS_OK;
      addr        <= 32'h0;
      remain      <= 32'h0;
      stop        <= 33'h0;
      word        <= bfch_pkg::ERASED_WORD;
      lane        <= 2'h0;
      to_flash    <= 1'b0;
      sec_byte    <= bfch_pkg::SECBYTE_RST;
      secured     <= bfch_pkg::SECURE_RST;
      last_status <= bfch_pkg::STATUS_OK;
    end else begin
      st          <= next_st;
      cmd         <= next_cmd;
      op          <= next_op;
      status      <= next_status;
      addr        <= next_addr;
      remain      <= next_remain;
      stop        <= next_stop;
      word        <= next_word;
      lane        <= next_lane;
      to_flash    <= next_to_flash;
      sec_byte    <= next_sec_byte;
      secured     <= next_secured;
      last_status <= next_last_status;
    end
  end

endmodule : bfch_top
`default_nettype wire

// [tb/bfch_checker.sv]
/*
  Port assertions for the command handler.
  Assumes a bind into bfch_top; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module bfch_checker (
  // Clock and reset.
  input wire logic                   ref_clk_in,
  input wire logic                   rst_b_in,
  // Command and reply side.
  input wire logic                   cmd_valid_in,
  input wire bfch_pkg::bfch_cmd_t    cmd_in,
  input wire logic                   cmd_ready_out,
  input wire logic                   data_ready_out,
  input wire logic                   reply_valid_out,
  input wire bfch_pkg::bfch_reply_t  reply_out,
  input wire logic                   reply_ready_in,
  // Memory side.
  input wire logic                   mem_req_out,
  input wire bfch_pkg::bfch_mem_op_t mem_op_out,
  input wire logic                   mem_done_in,
  input wire logic                   mem_fail_in,
  input wire logic                   flash_secured_out
);
  logic       tk;
  logic [7:0] tg;
  assign tk = cmd_valid_in && cmd_ready_out;
  assign tg = cmd_in.cmd_code_field;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  chk_busy_after_take: assert property (tk |=> !cmd_ready_out)
    else $error("ready after take");
  chk_reply_held: assert property (reply_valid_out && !reply_ready_in |=> reply_valid_out && $stable(reply_out))
    else $error("reply not held");
  chk_op_held: assert property (mem_req_out && !mem_done_in |=> mem_req_out && $stable(mem_op_out))
    else $error("op not held");
  chk_align_first: assert property (tk && tg == bfch_pkg::TAG_REGION_ERASE
    && |{cmd_in.first_location_param[1:0], cmd_in.transfer_length_param[1:0]}
    |-> ##2 reply_valid_out && reply_out.status == bfch_pkg::STATUS_MISALIGNED)
    else $error("misaligned not refused");
  chk_erase_no_data: assert property (tk && (tg == bfch_pkg::TAG_FULL_ERASE || tg == bfch_pkg::TAG_UNSEC_ERASE)
    |=> !data_ready_out[*4])
    else $error("erase opened data phase");
  chk_sec_byte_val: assert property (mem_req_out && mem_op_out.kind == bfch_pkg::OP_PROGRAM
    && mem_op_out.addr == bfch_pkg::SEC_BYTE_ADDR |-> mem_op_out.data == 32'hffff_fffe)
    else $error("bad security byte value");
  chk_erase_unsec: assert property (mem_req_out && mem_done_in && !mem_fail_in
    && mem_op_out.kind == bfch_pkg::OP_ERASE_ALL |=> !flash_secured_out)
    else $error("security kept after erase");
  chk_verify_pair: assert property (mem_req_out && mem_op_out.kind == bfch_pkg::OP_VERIFY && $changed(mem_op_out.kind)
    |-> $past(mem_op_out.kind) == bfch_pkg::OP_PROGRAM && $stable(mem_op_out.addr))
    else $error("verify not after program");
  cov_ok_reply: cover property (reply_valid_out && reply_ready_in && reply_out.status == bfch_pkg::STATUS_OK);
  cov_verify: cover property (mem_req_out && mem_op_out.kind == bfch_pkg::OP_VERIFY);
  cov_fail: cover property (mem_req_out && mem_done_in && mem_fail_in);
endmodule : bfch_checker
`default_nettype wire

// [tb/bfch_mem_model.sv]
/*
  Memory controller model: one done pulse per operation.
  Assumes a request stays up until its done.
*/
`timescale 1ns/1ps
`default_nettype none
module bfch_mem_model (
  // Clock, reset and request.
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       req_in,
  // Pacing and commanded failure.
  input  wire logic [1:0] lag_in,
  input  wire logic       fail_in,
  // Answer.
  output logic            done_out,
  output logic            fail_out
);
  logic [1:0] cnt;
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || !req_in || done_out) begin
      cnt      <= 2'h0;
      done_out <= 1'b0;
    end else begin
      cnt      <= cnt + 2'h1;
      done_out <= (cnt == lag_in);
    end
  end
  // Outside a done pulse the failure line carries a changing pattern.
  assign fail_out = done_out ? fail_in : cnt[0];
endmodule : bfch_mem_model
`default_nettype wire

// [tb/bfch_top_tb_top.sv]
/*
  Self-checking bench for the command handler.
  Assumes the memory model as far side.
*/
`timescale 1ns/1ps
`default_nettype none
module bfch_top_tb_top;
  localparam int FL = 4096;
  localparam int SB = 1024;
  logic ref_clk_in = 1'b0, rst_b_in = 1'b0, cmd_valid_in = 1'b0, data_valid_in = 1'b0, reply_ready_in = 1'b1;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, pslverr_out, pready_out, perr;
  logic cmd_ready_out, data_ready_out, reply_valid_out, mem_req_out, mem_done_in, mem_fail_in, flash_secured_out;
  logic [7:0] data_byte_in = 8'h00;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic [1:0] lag = 2'h0;
  logic fail_cmd = 1'b0;
  bfch_pkg::bfch_cmd_t cmd_in = '0;
  bfch_pkg::bfch_reply_t reply_out;
  bfch_pkg::bfch_mem_op_t mem_op_out, e, g;
  logic [63:0] rq[$];
  bfch_pkg::bfch_mem_op_t oq[$];
  logic [7:0] nob[$];
  integer seed = 32'hac6a;
  int n_errors = 0, tests_run = 0, cyc = 0;
  bfch_top #(.FLASH_BYTES(FL), .SECTOR_BYTES(SB), .SECTORS(4)) bfch_top_inst (.*);
  bfch_mem_model bfch_mem_model_inst (.clk_in(ref_clk_in), .rst_b_in(rst_b_in), .req_in(mem_req_out),
    .lag_in(lag), .fail_in(fail_cmd), .done_out(mem_done_in), .fail_out(mem_fail_in));
  always #5 ref_clk_in = ~ref_clk_in;
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic cmp(input string s, input logic [66:0] x, y);
    tests_run++;
    if (y !== x) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", s, x, y);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    do @(posedge ref_clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    perr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask : apb
  task automatic po(input bfch_pkg::bfch_op_t k, input logic [31:0] a, input logic [31:0] d);
    oq.push_back('{k, a, d});
  endtask : po
  task automatic cmd(input logic [7:0] t, input logic [31:0] a, c, st, input logic [7:0] b[$]);
    rq.push_back({st, 24'h0, t});
    cmd_in <= '{t, 8'h00, (t == 8'h01 || t == 8'h0d) ? 8'h00 : 8'h02, a, c};
    cmd_valid_in <= 1'b1;
    do @(posedge ref_clk_in); while (cmd_ready_out !== 1'b1);
    cmd_valid_in <= 1'b0;
    foreach (b[i]) begin
      data_byte_in <= b[i];
      data_valid_in <= 1'b1;
      do @(posedge ref_clk_in); while (data_ready_out !== 1'b1);
    end
    data_valid_in <= 1'b0;
    while (rq.size() != 0) @(posedge ref_clk_in);
  endtask : cmd
  task automatic wr(input logic [31:0] a, input int n, input logic [31:0] st);
    logic [7:0] b[$];
    logic [31:0] w = '1;
    for (int i = 0; i < n; i++) begin
      b.push_back(8'($random(seed)));
      w[8*(i%4)+:8] = b[i];
      if (st === 32'h0 && a >= FL) po(bfch_pkg::OP_RAM_BYTE, 32'(a + i), {24'h0, b[i]});
      else if (st === 32'h0 && (i % 4 == 3 || i == n - 1)) begin
        po(bfch_pkg::OP_PROGRAM, 32'(a + i - i % 4), w);
        po(bfch_pkg::OP_VERIFY, 32'(a + i - i % 4), w);
        w = '1;
      end
    end
    cmd(bfch_pkg::TAG_MEM_WRITE, a, n, st, b);
  endtask : wr
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    lag <= 2'($random(seed));
    reply_ready_in <= 1'($random(seed));
    if (rst_b_in && reply_valid_out && reply_ready_in) cmp("reply", rq.pop_front(), reply_out);
    if (rst_b_in && mem_req_out && mem_done_in) begin
      e = oq.pop_front();
      g = mem_op_out;
      if (e.kind == bfch_pkg::OP_ERASE_ALL) g.addr = e.addr;
      if (e.kind inside {bfch_pkg::OP_ERASE_ALL, bfch_pkg::OP_ERASE_SECTOR}) g.data = e.data;
      if (e.kind == bfch_pkg::OP_RAM_BYTE) g.data[31:8] = e.data[31:8];
      cmp("memop", e, g);
    end
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    logic [31:0] ra[5] = '{32'h2, 32'h0, FL - 4, FL + 2, SB};
    logic [31:0] rc[5] = '{32'h4, 32'h6, 32'h8, 32'h4, 32'h4};
    logic [31:0] rs[5] = '{32'h65, 32'h65, 32'h66, 32'h65, 32'h27d8};
    repeat (2) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    apb(1'b0, 12'h020, 32'h0);
    cmp("unmapped", 1'b1, perr);
    apb(1'b1, bfch_pkg::REG_SECURE, 32'h1);
    apb(1'b1, bfch_pkg::REG_PROT, 32'h1);
    cmd(bfch_pkg::TAG_FULL_ERASE, 0, 0, bfch_pkg::STATUS_PROT_FAULT, nob);
    apb(1'b1, bfch_pkg::REG_PROT, 32'h0);
    po(bfch_pkg::OP_ERASE_ALL, 0, 0);
    cmd(bfch_pkg::TAG_FULL_ERASE, 0, 0, 32'h0, nob);
    cmp("secured", 1'b0, flash_secured_out);
    apb(1'b1, bfch_pkg::REG_PROT, 32'h2);
    for (int i = 0; i < 5; i++) cmd(bfch_pkg::TAG_REGION_ERASE, ra[i], rc[i], rs[i], nob);
    po(bfch_pkg::OP_ERASE_SECTOR, 2 * SB, 0);
    po(bfch_pkg::OP_ERASE_SECTOR, 3 * SB, 0);
    cmd(bfch_pkg::TAG_REGION_ERASE, 2 * SB, SB + 4, 32'h0, nob);
    fail_cmd <= 1'b1;
    po(bfch_pkg::OP_ERASE_SECTOR, 0, 0);
    cmd(bfch_pkg::TAG_REGION_ERASE, 0, 4, bfch_pkg::STATUS_OP_FAILED, nob);
    fail_cmd <= 1'b0;
    apb(1'b1, bfch_pkg::REG_SECBYTE, 32'h20);
    cmd(bfch_pkg::TAG_UNSEC_ERASE, 0, 0, bfch_pkg::STATUS_OP_FAILED, nob);
    apb(1'b1, bfch_pkg::REG_SECBYTE, 32'hff);
    apb(1'b1, bfch_pkg::REG_SECURE, 32'h1);
    po(bfch_pkg::OP_ERASE_ALL, 0, 0);
    po(bfch_pkg::OP_PROGRAM, bfch_pkg::SEC_BYTE_ADDR, 32'hffff_fffe);
    cmd(bfch_pkg::TAG_UNSEC_ERASE, 0, 0, 32'h0, nob);
    cmp("secured", 1'b0, flash_secured_out);
    apb(1'b0, bfch_pkg::REG_SECBYTE, 32'h0);
    cmp("secbyte", 8'hfe, rd[7:0]);
    // Flash was mass erased above, so the writes below land on erased sectors.
    apb(1'b1, bfch_pkg::REG_CTRL, 32'h1);
    wr(32'h100, 5, 32'h0);
    wr(32'h102, 2, bfch_pkg::STATUS_MISALIGNED);
    wr(SB, 4, bfch_pkg::STATUS_PROT_FAULT);
    wr(FL + 3, 3, 32'h0);
    end_sim();
  end
endmodule : bfch_top_tb_top
bind bfch_top bfch_checker bfch_checker_inst (.*);
`default_nettype wire
